// file: ppc_params.svh
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH

// Register byte offsets
`define PPC_OFS_CTRL      8'h00
`define PPC_OFS_MODE      8'h04
`define PPC_OFS_TARGET    8'h08
`define PPC_OFS_SPEED     8'h0C
`define PPC_OFS_ACCEL     8'h10
`define PPC_OFS_DECEL     8'h14
`define PPC_OFS_STATUS    8'h18
`define PPC_OFS_MODE_DISP 8'h1C

// Control word patterns and bits
`define PPC_CW_DISABLE    16'h0000
`define PPC_CW_SHUTDOWN   16'h0006
`define PPC_CW_SWITCHED   16'h0007
`define PPC_CW_EN_NIBBLE  4'hF
`define PPC_CW_NEW_SP     4
`define PPC_CW_IMMED      5
`define PPC_CW_REL        6
`define PPC_CW_HALT       8

// Status word base patterns and bits
`define PPC_SW_DISABLED   16'h0050
`define PPC_SW_READY      16'h0031
`define PPC_SW_STARTED    16'h0033
`define PPC_SW_ENABLED    16'h0037
`define PPC_SW_REACHED    10
`define PPC_SW_ACK        12

// Mode selector value for profile position
`define PPC_MODE_PROFILE  8'h01

// Reset values and bus answers
`define PPC_RST_WORD      32'h0000_0000
`define PPC_RESP_OKAY     2'h0
`define PPC_RESP_SLVERR   2'h2

`endif

// file: ppc_pkg.sv
package ppc_pkg;

  typedef enum logic [1:0] {
    PPC_ST_DISABLED,
    PPC_ST_READY,
    PPC_ST_STARTED,
    PPC_ST_ENABLED
  } ppc_state_e;

  typedef struct packed {
    logic [31:0] target;
    logic [31:0] speed;
    logic [31:0] accel;
    logic [31:0] decel;
    logic        relative;
  } ppc_prof_s;

endpackage

// file: ppc_sequencer.sv
`timescale 1ns/100ps
`include "ppc_params.svh"

module ppc_sequencer
  import ppc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        move_done_i,
  input  wire logic        axis_still_i,
  output logic             start_o,
  output logic             immediate_o,
  output logic             halt_o,
  output logic             mode_run_o,
  output ppc_prof_s        prof_o
);

  logic        aw_q;
  logic [7:0]  awaddr_q;
  logic        w_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] ctrl_q;
  logic [31:0] mode_q;
  logic [31:0] target_q;
  logic [31:0] speed_q;
  logic [31:0] accel_q;
  logic [31:0] decel_q;
  ppc_state_e  state_q;
  ppc_state_e  state_d;
  logic [7:0]  mode_act_q;
  logic        sp_prev_q;
  logic        busy_q;
  logic        pending_q;
  logic        ack_q;
  logic        start_q;
  logic        immed_q;
  logic        halt_q;
  ppc_prof_s   prof_q;
  ppc_prof_s   pend_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  wire        wr_go      = aw_q && w_q && !bvalid_q;
  wire        wr_ctrl    = wr_go && (awaddr_q == `PPC_OFS_CTRL);
  wire        wr_mode    = wr_go && (awaddr_q == `PPC_OFS_MODE);
  wire        wr_target  = wr_go && (awaddr_q == `PPC_OFS_TARGET);
  wire        wr_speed   = wr_go && (awaddr_q == `PPC_OFS_SPEED);
  wire        wr_accel   = wr_go && (awaddr_q == `PPC_OFS_ACCEL);
  wire        wr_decel   = wr_go && (awaddr_q == `PPC_OFS_DECEL);
  wire        wr_mapped  = wr_ctrl || wr_mode || wr_target || wr_speed || wr_accel || wr_decel;
  wire        rd_go      = s_axi_arvalid && !rvalid_q;
  wire [15:0] cw         = ctrl_q[15:0];
  wire        en_pat     = (cw[3:0] == `PPC_CW_EN_NIBBLE);
  wire        sp_edge    = cw[`PPC_CW_NEW_SP] && !sp_prev_q;
  wire        motion_ok  = en_pat && (state_q == PPC_ST_STARTED || state_q == PPC_ST_ENABLED) &&
                           (mode_act_q == `PPC_MODE_PROFILE);
  wire        accept     = sp_edge && motion_ok && !cw[`PPC_CW_HALT];
  wire        take_now   = accept && (!busy_q || cw[`PPC_CW_IMMED]);
  wire        take_later = accept && busy_q && !cw[`PPC_CW_IMMED];
  // Queued profile also leaves once idle, so a done pulse racing the queue is not lost
  wire        launch_pnd = pending_q && (move_done_i || !busy_q) && motion_ok && !cw[`PPC_CW_HALT];
  wire        stopping   = (state_q == PPC_ST_ENABLED) && !en_pat;
  wire        reached    = halt_q ? axis_still_i : (!busy_q && !pending_q);
  ppc_prof_s  prof_new;
  logic [15:0] status_w;

  assign prof_new = '{target: target_q, speed: speed_q, accel: accel_q, decel: decel_q,
                      relative: cw[`PPC_CW_REL]};

  always_comb begin
    case (state_q)
      PPC_ST_READY:   status_w = `PPC_SW_READY;
      PPC_ST_STARTED: status_w = `PPC_SW_STARTED;
      PPC_ST_ENABLED: status_w = `PPC_SW_ENABLED;
      default:        status_w = `PPC_SW_DISABLED;
    endcase
    status_w[`PPC_SW_REACHED] = reached;
    status_w[`PPC_SW_ACK]     = ack_q;
  end

  // Power stage sequence; any 0xnnnF from started enables directly
  always_comb begin
    state_d = state_q;
    case (state_q)
      PPC_ST_DISABLED: begin
        if (cw == `PPC_CW_SHUTDOWN) state_d = PPC_ST_READY;
      end
      PPC_ST_READY: begin
        if (cw == `PPC_CW_SWITCHED) state_d = PPC_ST_STARTED;
        else if (cw == `PPC_CW_DISABLE) state_d = PPC_ST_DISABLED;
      end
      PPC_ST_STARTED: begin
        if (en_pat) state_d = PPC_ST_ENABLED;
        else if (cw == `PPC_CW_SHUTDOWN) state_d = PPC_ST_READY;
        else if (cw == `PPC_CW_DISABLE) state_d = PPC_ST_DISABLED;
      end
      PPC_ST_ENABLED: begin
        if (cw == `PPC_CW_SWITCHED) state_d = PPC_ST_STARTED;
        else if (cw == `PPC_CW_SHUTDOWN) state_d = PPC_ST_READY;
        else if (cw == `PPC_CW_DISABLE) state_d = PPC_ST_DISABLED;
      end
      default: state_d = PPC_ST_DISABLED;
    endcase
  end

  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready  = !w_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign start_o       = start_q;
  assign immediate_o   = immed_q;
  assign halt_o        = halt_q;
  assign mode_run_o    = (state_q == PPC_ST_ENABLED) && (mode_act_q == `PPC_MODE_PROFILE);
  assign prof_o        = prof_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q     <= 1'b0;
      awaddr_q <= 8'h00;
      w_q      <= 1'b0;
      wdata_q  <= `PPC_RST_WORD;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `PPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_mapped ? `PPC_RESP_OKAY : `PPC_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q   <= `PPC_RST_WORD;
      mode_q   <= `PPC_RST_WORD;
      target_q <= `PPC_RST_WORD;
      speed_q  <= `PPC_RST_WORD;
      accel_q  <= `PPC_RST_WORD;
      decel_q  <= `PPC_RST_WORD;
    end else begin
      if (wr_ctrl)   ctrl_q   <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_FFFF;
      if (wr_mode)   mode_q   <= merge(mode_q, wdata_q, wstrb_q) & 32'h0000_00FF;
      if (wr_target) target_q <= merge(target_q, wdata_q, wstrb_q);
      if (wr_speed)  speed_q  <= merge(speed_q, wdata_q, wstrb_q);
      if (wr_accel)  accel_q  <= merge(accel_q, wdata_q, wstrb_q);
      if (wr_decel)  decel_q  <= merge(decel_q, wdata_q, wstrb_q);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= `PPC_RST_WORD;
      rresp_q  <= `PPC_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `PPC_RESP_OKAY;
      case (s_axi_araddr)
        `PPC_OFS_CTRL:      rdata_q <= ctrl_q;
        `PPC_OFS_MODE:      rdata_q <= mode_q;
        `PPC_OFS_TARGET:    rdata_q <= target_q;
        `PPC_OFS_SPEED:     rdata_q <= speed_q;
        `PPC_OFS_ACCEL:     rdata_q <= accel_q;
        `PPC_OFS_DECEL:     rdata_q <= decel_q;
        `PPC_OFS_STATUS:    rdata_q <= {16'h0000, status_w};
        `PPC_OFS_MODE_DISP: rdata_q <= {24'h000000, mode_act_q};
        default: begin
          rdata_q <= `PPC_RST_WORD;
          rresp_q <= `PPC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Mode switch while enabled could start the new mode mid-motion, so it is frozen there
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= PPC_ST_DISABLED;
      mode_act_q <= 8'h00;
      sp_prev_q  <= 1'b0;
      halt_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      sp_prev_q <= cw[`PPC_CW_NEW_SP];
      halt_q    <= motion_ok && cw[`PPC_CW_HALT];
      if (state_q != PPC_ST_ENABLED) mode_act_q <= mode_q[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q    <= 1'b0;
      pending_q <= 1'b0;
      ack_q     <= 1'b0;
      start_q   <= 1'b0;
      immed_q   <= 1'b0;
      prof_q    <= '0;
      pend_q    <= '0;
    end else begin
      start_q <= 1'b0;
      immed_q <= 1'b0;
      if (!cw[`PPC_CW_NEW_SP]) ack_q <= 1'b0;
      if (accept) ack_q <= 1'b1;
      if (stopping) begin
        busy_q    <= 1'b0;
        pending_q <= 1'b0;
      end else if (take_now) begin
        busy_q    <= 1'b1;
        pending_q <= 1'b0;
        prof_q    <= prof_new;
        start_q   <= 1'b1;
        immed_q   <= busy_q;
      end else if (take_later) begin
        pending_q <= 1'b1;
        pend_q    <= prof_new;
        if (move_done_i) busy_q <= 1'b0;
      end else if (launch_pnd) begin
        pending_q <= 1'b0;
        busy_q    <= 1'b1;
        prof_q    <= pend_q;
        start_q   <= 1'b1;
      end else if (move_done_i) begin
        busy_q <= 1'b0;
      end
    end
  end

  chk_start_gated: assert property (@(posedge clk) disable iff (rst)
    start_q |-> $past(motion_ok)) else $error("start without enabled pattern");

  chk_stop_clears: assert property (@(posedge clk) disable iff (rst)
    (state_q == PPC_ST_ENABLED && cw == `PPC_CW_SWITCHED) |=> (!mode_run_o && !busy_q && !pending_q))
    else $error("stop did not end the mode");

  chk_restart_mode: assert property (@(posedge clk) disable iff (rst)
    (state_q == PPC_ST_STARTED && en_pat) |=> state_q == PPC_ST_ENABLED) else $error("no restart");

  chk_queue_waits: assert property (@(posedge clk) disable iff (rst)
    (take_later && !stopping) |=> (pending_q && !start_q)) else $error("queued move started early");

  chk_queue_launch: assert property (@(posedge clk) disable iff (rst)
    (launch_pnd && !stopping && !accept) |=> (start_q && !pending_q && prof_o == $past(pend_q)))
    else $error("queued move not launched");

  chk_immed_swap: assert property (@(posedge clk) disable iff (rst)
    (take_now && busy_q && !stopping) |=> (start_q && immediate_o)) else $error("no immediate change");

  chk_halt_level: assert property (@(posedge clk) disable iff (rst)
    (motion_ok && cw[`PPC_CW_HALT]) |=> (halt_o && !start_q)) else $error("halt not applied");

  chk_mode_frozen: assert property (@(posedge clk) disable iff (rst)
    (state_q == PPC_ST_ENABLED) |=> $stable(mode_act_q)) else $error("mode changed while enabled");

  chk_ack_follows: assert property (@(posedge clk) disable iff (rst)
    accept |=> status_w[`PPC_SW_ACK]) else $error("target not acknowledged");

  chk_level_only: assert property (@(posedge clk) disable iff (rst)
    (!sp_edge && !launch_pnd) |=> !start_q) else $error("start without strobe edge");

  chk_abs_rel: assert property (@(posedge clk) disable iff (rst)
    (take_now && !stopping) |=> prof_o.relative == $past(cw[`PPC_CW_REL])) else $error("bad target type");

endmodule

// file: ppc_gen_model.sv
`timescale 1ns/100ps
module ppc_gen_model #(
  parameter int MOVE_CYC = 60
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start_i,
  input  wire logic halt_i,
  output logic      done_o,
  output logic      still_o,
  output logic      busy_o
);
  logic [7:0] cnt_q;
  logic [1:0] hcnt_q;
  // Halt freezes travel, resumes once halt drops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 8'h00;
      hcnt_q <= 2'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= !start_i && cnt_q == 8'h01 && !halt_i;
      hcnt_q <= !halt_i ? 2'h0 : (hcnt_q == 2'h3 ? hcnt_q : hcnt_q + 2'h1);
      if (start_i)
        cnt_q <= 8'(MOVE_CYC);
      else if (cnt_q != 8'h00 && !halt_i)
        cnt_q <= cnt_q - 8'h01;
    end
  end
  // Short ramp: speed zero a few cycles after halt
  assign still_o = (cnt_q == 8'h00) || (hcnt_q == 2'h3);
  assign busy_o  = cnt_q != 8'h00;
endmodule

// file: tb_ppc_sequencer.sv
`timescale 1ns/100ps
`include "ppc_params.svh"
module tb_ppc_sequencer import ppc_pkg::*;;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        move_done_i, axis_still_i, start_o, immediate_o, halt_o, mode_run_o, gen_busy, last_imm;
  ppc_prof_s   prof_o, last_prof;
  int          bad_count = 0, total_checks = 0, n_start = 0, c;
  logic [31:0] seq_cw[4] = '{32'h0, 32'h6, 32'h7, 32'hF};
  logic [31:0] seq_sw[4] = '{32'h50, 32'h31, 32'h33, 32'h37};
  logic [31:0] mv_cw[4] = '{32'h1F, 32'h5F, 32'h3F, 32'h7F};

  always #12.5 clk = ~clk;

  ppc_sequencer uut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .move_done_i, .axis_still_i, .start_o, .immediate_o, .halt_o, .mode_run_o, .prof_o
  );
  ppc_gen_model #(.MOVE_CYC(60)) gen (
    .clk, .rst, .start_i(start_o), .halt_i(halt_o), .done_o(move_done_i), .still_o(axis_still_i),
    .busy_o(gen_busy)
  );

  // Profile captured as start fires, since start_o stands one cycle
  always @(posedge clk) begin
    if (start_o === 1'b1) begin
      n_start <= n_start + 1;
      last_prof <= prof_o;
      last_imm <= immediate_o;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `PPC_RESP_OKAY);
    bit ad, dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready === 1'b1) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                    input logic [1:0] er = `PPC_RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", exp, s_axi_rdata & m);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge clk);
  endtask

  task automatic idle;
    while (gen_busy !== 1'b0) @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`PPC_OFS_CTRL, '1, 32'h0);
    rd(8'h20, '1, 32'h0, `PPC_RESP_SLVERR);
    wr(`PPC_OFS_STATUS, 32'hFFFF, `PPC_RESP_SLVERR);
    $display("test reset_and_bus done");
    wr(`PPC_OFS_MODE, 32'h1);
    foreach (seq_cw[i]) begin
      wr(`PPC_OFS_CTRL, seq_cw[i]);
      rd(`PPC_OFS_STATUS, 32'hFF, seq_sw[i]);
    end
    chk("mode_run", 32'h1, {31'h0, mode_run_o});
    wr(`PPC_OFS_TARGET, 32'h1000);
    wr(`PPC_OFS_SPEED, 32'h20);
    wr(`PPC_OFS_ACCEL, 32'h8);
    wr(`PPC_OFS_DECEL, 32'h8);
    $display("test enable done");
    c = n_start;
    wr(`PPC_OFS_CTRL, 32'h1F);
    repeat (4) @(posedge clk);
    chk("starts", c + 1, n_start);
    chk("target", 32'h1000, last_prof.target);
    chk("speed", 32'h20, last_prof.speed);
    chk("accel", 32'h8, last_prof.accel);
    chk("decel", 32'h8, last_prof.decel);
    rd(`PPC_OFS_STATUS, 32'h1400, 32'h1000);
    repeat (5) @(posedge clk);
    chk("starts", c + 1, n_start);
    wr(`PPC_OFS_CTRL, 32'hF);
    rd(`PPC_OFS_STATUS, 32'h1000, 32'h0);
    idle();
    $display("test single_move done");
    foreach (mv_cw[i]) begin
      c = n_start;
      wr(`PPC_OFS_CTRL, 32'h1F);
      repeat (4) @(posedge clk);
      wr(`PPC_OFS_CTRL, 32'hF);
      wr(`PPC_OFS_TARGET, 32'h100 + i);
      wr(`PPC_OFS_CTRL, mv_cw[i]);
      repeat (4) @(posedge clk);
      chk("early_starts", c + 1 + mv_cw[i][5], n_start);
      while (n_start == c + 1) @(posedge clk);
      chk("immediate", {31'h0, mv_cw[i][5]}, {31'h0, last_imm});
      chk("target", 32'h100 + i, last_prof.target);
      chk("relative", {31'h0, mv_cw[i][6]}, {31'h0, last_prof.relative});
      wr(`PPC_OFS_CTRL, 32'hF);
      idle();
    end
    $display("test queue_and_replace done");
    c = n_start;
    wr(`PPC_OFS_CTRL, 32'h1F);
    repeat (4) @(posedge clk);
    wr(`PPC_OFS_CTRL, 32'hF);
    wr(`PPC_OFS_CTRL, 32'h11F);
    repeat (4) @(posedge clk);
    chk("halt", 32'h1, {31'h0, halt_o});
    chk("starts", c + 1, n_start);
    rd(`PPC_OFS_STATUS, 32'h4FF, 32'h437);
    wr(`PPC_OFS_CTRL, 32'hF);
    repeat (2) @(posedge clk);
    chk("halt", 32'h0, {31'h0, halt_o});
    idle();
    $display("test halt done");
    c = n_start;
    wr(`PPC_OFS_CTRL, 32'h7);
    rd(`PPC_OFS_STATUS, 32'hFF, 32'h33);
    chk("mode_run", 32'h0, {31'h0, mode_run_o});
    wr(`PPC_OFS_MODE, 32'h6);
    rd(`PPC_OFS_MODE_DISP, 32'hFF, 32'h6);
    wr(`PPC_OFS_CTRL, 32'h1F);
    repeat (4) @(posedge clk);
    chk("starts", c, n_start);
    wr(`PPC_OFS_MODE, 32'h1);
    rd(`PPC_OFS_MODE_DISP, 32'hFF, 32'h6);
    wr(`PPC_OFS_CTRL, 32'h7);
    wr(`PPC_OFS_CTRL, 32'h17);
    repeat (4) @(posedge clk);
    chk("starts", c, n_start);
    wr(`PPC_OFS_CTRL, 32'h7);
    wr(`PPC_OFS_CTRL, 32'h1F);
    repeat (4) @(posedge clk);
    chk("starts", c + 1, n_start);
    chk("mode_run", 32'h1, {31'h0, mode_run_o});
    idle();
    $display("test stop_restart done");
    report_and_stop();
  end
endmodule
